/* File: dv/adc_ctrl_sva.sv */
// Protocol and control checks seen from the pins of the converter control block.
module adc_ctrl_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] mux_onehot,
    input wire logic ref_gen_en,
    input wire logic mod_run,
    input wire logic irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Two inputs on the converter at once would short the sources together.
    mux_onehot_a: assert property ($onehot0(mux_onehot)) else $error("mux select not one-hot");
    mux_write_a: assert property ($changed(mux_onehot) |-> $rose(s_axi_bvalid)) else $error("mux moved");
    ref_write_a: assert property ($changed(ref_gen_en) |-> $rose(s_axi_bvalid)) else $error("ref moved");
    run_start_a: assert property ($rose(mod_run) |-> $rose(s_axi_bvalid)) else $error("run without write");
    run_hold_a: assert property ($rose(mod_run) |=> mod_run [*8]) else $error("run dropped early");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready during response");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during read data");
    cover property ($fell(mod_run));
    cover property ($rose(irq));
    cover property ($rose(mod_run));
endmodule : adc_ctrl_sva

bind adc_ctrl adc_ctrl_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mux_onehot(mux_onehot),
    .ref_gen_en(ref_gen_en), .mod_run(mod_run), .irq(irq));

/* File: dv/adc_ctrl_tb.sv */
`include "adc_cfg.svh"

module adc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, mod_bit = 0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, ref_gen_en, mod_run, irq;
    logic [4:0] mux_onehot;
    logic [31:0] d, r;
    int err_count = 0, tests_run = 0, cyc = 0, t0, t1;
    adc_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mod_bit(mod_bit),
        .mux_onehot(mux_onehot), .ref_gen_en(ref_gen_en), .mod_run(mod_run), .irq(irq));
    always #10 sys_clk = ~sys_clk;
    // A toggling bit stream gives exactly half ones in every slice, whatever the phase.
    always @(posedge sys_clk) begin
        mod_bit <= ~mod_bit;
        cyc <= cyc + 1;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One write; returns at the edge where the response is taken.
    task wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid);
        r = {30'h0, bresp};
        bready <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arv <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = {30'h0, rresp};
        rready <= 1'b0;
    endtask : rd
    // Waits for irq high or mod_run low and stamps the cycle.
    task wait_ev(input bit on_irq, output int t);
        do begin
            @(posedge sys_clk);
            #1;
        end while (on_irq ? !irq : mod_run);
        t = cyc;
    endtask : wait_ev
    task stop_test;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // Two conversions of about 5200 cycles each, a 1000-cycle restarted run and two repeat slices fit well inside this span.
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_count++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(`ADC_CTRL_ADDR);
        chk(d, 32'h20);
        chk(ref_gen_en, 1'b0);
        rd(`ADC_MASK_ADDR);
        chk(d, 32'h0);
        rd(12'hF80);
        chk(r, 32'h2);
        chk(d, 32'h0);
        // An unmapped write is refused with an error response and changes nothing.
        wr(12'hF80, 8'h01);
        chk(r, 32'h2);
        // A write without the low byte lane must leave the mask alone.
        wstrb <= 4'hE;
        wr(`ADC_MASK_ADDR, 8'h01);
        wstrb <= 4'hF;
        rd(`ADC_MASK_ADDR);
        chk(d, 32'h0);
        // Software only names inputs that exist and always writes bit 6 as zero.
        for (int c = 0; c < 5; c++) begin
            wr(`ADC_CTRL_ADDR, 8'(c));
            chk(r, 32'h0);
            chk(mux_onehot, 32'(1 << c));
            chk(ref_gen_en, 1'b1);
        end
        wr(`ADC_CTRL_ADDR, 8'h24);
        chk(ref_gen_en, 1'b0);
        chk(mux_onehot, 5'h10);
        wr(`ADC_MASK_ADDR, 8'h01);
        wr(`ADC_CTRL_ADDR, 8'h82);
        #1 t0 = cyc;
        wait_ev(1'b0, t1);
        chk(t1 - t0, 32'h1409);
        chk(irq, 1'b1);
        rd(`ADC_CTRL_ADDR);
        chk(d, 32'h02);
        rd(`ADC_RESULT_ADDR);
        chk(d, 32'h200);
        wr(`ADC_STATUS_ADDR, 8'h01);
        chk(irq, 1'b0);
        // A zero write mid-run must not stop it; a second start restarts the count.
        wr(`ADC_CTRL_ADDR, 8'h80);
        repeat (1000) @(posedge sys_clk);
        wr(`ADC_CTRL_ADDR, 8'h00);
        rd(`ADC_CTRL_ADDR);
        chk(d[7], 1'b1);
        wr(`ADC_CTRL_ADDR, 8'h80);
        #1 t0 = cyc;
        wait_ev(1'b0, t1);
        chk(t1 - t0, 32'h1409);
        wr(`ADC_MASK_ADDR, 8'h00);
        chk(irq, 1'b0);
        wr(`ADC_MASK_ADDR, 8'h01);
        chk(irq, 1'b1);
        wr(`ADC_STATUS_ADDR, 8'h01);
        wr(`ADC_CTRL_ADDR, 8'h90);
        #1 t0 = cyc;
        wait_ev(1'b1, t1);
        chk(t1 - t0, 32'h100);
        wr(`ADC_STATUS_ADDR, 8'h01);
        wait_ev(1'b1, t0);
        chk(t0 - t1, 32'h100);
        chk(mod_run, 1'b1);
        wr(`ADC_CTRL_ADDR, 8'h00);
        wait_ev(1'b0, t0);
        chk(mod_run, 1'b0);
        stop_test;
    end
endmodule : adc_ctrl_tb

/* File: hdl/adc_cfg.svh */
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// Register byte addresses on the AXI4-Lite slave.
`define ADC_CTRL_ADDR 12'hF70
`define ADC_RESULT_ADDR 12'hF74
`define ADC_STATUS_ADDR 12'hF78
`define ADC_MASK_ADDR 12'hF7C

// Control register field positions.
`define ADC_CTRL_GO_BIT 7
`define ADC_CTRL_RSV_BIT 6
`define ADC_CTRL_EXTREF_BIT 5
`define ADC_CTRL_REPEAT_BIT 4
`define ADC_CTRL_CHAN_LSB 0

// Reset values.
`define ADC_CTRL_RESET 8'h20
`define ADC_MASK_RESET 1'h0

// Conversion timing in system clock cycles.
`define ADC_SINGLE_CYCLES 13'h1409
`define ADC_REPEAT_MODE_SELECT_CYCLES 13'h0100

// Number of analog inputs and AXI responses.
`define ADC_NUM_INPUTS 5
`define ADC_RESP_OKAY 2'h0
`define ADC_RESP_SLVERR 2'h2

`endif

/* File: hdl/adc_ctrl.sv */
// Functional notes
// - Each conversion yields a 10-bit binary result.
// - Exactly one of five analog inputs is routed to the converter; the code routes none for channel codes above 0100.
// - Conversion completion raises an interrupt request.
// - Control register at F70: go, reserved, reference, repeat mode, channel.
// - Writing go as 1 starts a conversion on the selected channel.
// - Writing go as 1 during a conversion restarts it from the beginning.
// - Go reads 1 during conversion and hardware clears it on completion; in repeat mode the code leaves go set.
// - Writing go as 0 changes nothing.
// - Single-shot mode presents one result after 5129 cycles.
// - Repeat mode updates the result every 256 cycles.
// - Reference bit 0 enables internal reference, 1 selects external pin.
// - Channel codes 0000 to 0100 select inputs zero to four.
//
// Added by the designer: the AXI4-Lite register port.
`include "adc_cfg.svh"

module adc_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mod_bit,
    output logic [4:0] mux_onehot,
    output logic ref_gen_en,
    output logic mod_run,
    output logic irq
);

    adc_pkg::top_state_t s_q, s_d;
    logic eng_start;
    logic eng_done;
    logic [9:0] eng_result;

    // Maps a channel code to a one-hot mux select; unused codes select nothing.
    function automatic logic [4:0] chan_decode(input logic [3:0] code);
        chan_decode = 5'h00;
        if (code < 4'(`ADC_NUM_INPUTS)) begin
            chan_decode = 5'(5'h01 << code);
        end
    endfunction : chan_decode

    // Returns the readable view of a register, or flags the address as unmapped.
    function automatic logic [32:0] reg_read(input logic [11:0] a, input adc_pkg::top_state_t s);
        reg_read = {1'b0, 32'h0000_0000};
        unique case (a)
            `ADC_CTRL_ADDR: reg_read = {1'b0, 24'h000000, s.ctl};
            `ADC_RESULT_ADDR: reg_read = {1'b0, 22'h000000, s.result};
            `ADC_STATUS_ADDR: reg_read = {1'b0, 31'h00000000, s.status};
            `ADC_MASK_ADDR: reg_read = {1'b0, 31'h00000000, s.mask};
            default: reg_read = {1'b1, 32'h0000_0000};
        endcase
    endfunction : reg_read

    // Register file, bus slave and conversion control all live in one state word.
    always_comb begin
        logic do_write;
        logic go_write;
        logic [32:0] rd;
        do_write = 1'b0;
        go_write = 1'b0;
        rd = 33'h0_0000_0000;
        eng_start = 1'b0;
        s_d = s_q;

        // Address and data are taken independently, in either order.
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata[7:0];
            s_d.w_strb0 = s_axi_wstrb[0];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;

        // Completion clears go outside repeat mode; a fresh go write in the same cycle still wins.
        if (eng_done) begin
            s_d.result = eng_result;
            s_d.status = 1'b1;
            if (!s_q.ctl.repeat_mode) begin
                s_d.ctl.go = 1'b0;
            end
        end

        if (do_write) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `ADC_RESP_OKAY;
            unique case (s_q.aw_addr)
                `ADC_CTRL_ADDR: begin
                    if (s_q.w_strb0) begin
                        // Only a one on go has effect; a zero leaves go and the conversion alone.
                        s_d.ctl.rsv = s_q.w_data[`ADC_CTRL_RSV_BIT];
                        s_d.ctl.ext_ref = s_q.w_data[`ADC_CTRL_EXTREF_BIT];
                        s_d.ctl.repeat_mode = s_q.w_data[`ADC_CTRL_REPEAT_BIT];
                        s_d.ctl.channel_select = s_q.w_data[`ADC_CTRL_CHAN_LSB +: 4];
                        go_write = s_q.w_data[`ADC_CTRL_GO_BIT];
                    end
                end
                `ADC_RESULT_ADDR: begin
                end
                `ADC_STATUS_ADDR: begin
                    // Write one to clear, but a completion in this cycle keeps the bit set.
                    if (s_q.w_strb0 && s_q.w_data[0] && !eng_done) begin
                        s_d.status = 1'b0;
                    end
                end
                `ADC_MASK_ADDR: begin
                    if (s_q.w_strb0) begin
                        s_d.mask = s_q.w_data[0];
                    end
                end
                default: s_d.bresp = `ADC_RESP_SLVERR;
            endcase
        end

        // Go as one starts a conversion, or restarts one under way.
        if (go_write) begin
            s_d.ctl.go = 1'b1;
            eng_start = 1'b1;
        end

        // Read channel: one outstanding read, answered the cycle after it is taken.
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            rd = reg_read(s_axi_araddr, s_q);
            s_d.rvalid = 1'b1;
            s_d.rdata = rd[31:0];
            s_d.rresp = rd[32] ? `ADC_RESP_SLVERR : `ADC_RESP_OKAY;
        end

        s_d.awready = !s_d.aw_held && !s_d.bvalid;
        s_d.wready = !s_d.w_held && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;

        // Analog-side controls follow the control register directly.
        s_d.mux_onehot = chan_decode(s_d.ctl.channel_select);
        s_d.ref_gen_en = !s_d.ctl.ext_ref;
        s_d.mod_run = s_d.ctl.go;
        // Computed from the next state so the request rises with the clearing of go.
        s_d.irq = s_d.status && s_d.mask;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctl <= `ADC_CTRL_RESET;
            s_q.mask <= `ADC_MASK_RESET;
            s_q.ref_gen_en <= 1'b0;
            // Channel zero is selected from reset, so the mux must not jump on the first edge after release.
            s_q.mux_onehot <= 5'h01;
        end else begin
            s_q <= s_d;
        end
    end

    // The engine runs while go is set; its history is wiped by every go write.
    conv_engine u_engine (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(eng_start),
        .run(s_q.ctl.go),
        .repeat_mode(s_q.ctl.repeat_mode),
        .mod_bit(mod_bit),
        .done(eng_done),
        .result(eng_result)
    );

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign mux_onehot = s_q.mux_onehot;
    assign ref_gen_en = s_q.ref_gen_en;
    assign mod_run = s_q.mod_run;
    assign irq = s_q.irq;

endmodule : adc_ctrl

/* File: hdl/adc_pkg.sv */
package adc_pkg;

    // Control register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic go;
        logic rsv;
        logic ext_ref;
        logic repeat_mode;
        logic [3:0] channel_select;
    } converter_control_t;

    // State of the decimating conversion engine.
    typedef struct packed {
        logic [12:0] cnt;
        logic [8:0] acc;
        logic [3:0][8:0] part;
        logic done;
        logic [9:0] result;
    } engine_state_t;

    // State of the register file and bus slave.
    typedef struct packed {
        logic awready;
        logic aw_held;
        logic [11:0] aw_addr;
        logic wready;
        logic w_held;
        logic [7:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        converter_control_t ctl;
        logic [9:0] result;
        logic status;
        logic mask;
        logic irq;
        logic [4:0] mux_onehot;
        logic ref_gen_en;
        logic mod_run;
    } top_state_t;

endpackage : adc_pkg

/* File: hdl/conv_engine.sv */
`include "adc_cfg.svh"

// Decimator for the modulator bit stream: ones are counted in 256-cycle slices and the
// last four slices are summed into a 10-bit result.
module conv_engine (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic run,
    input wire logic repeat_mode,
    input wire logic mod_bit,
    output logic done,
    output logic [9:0] result
);

    adc_pkg::engine_state_t s_q, s_d;

    // Sums four slices and saturates, since four full slices reach 1024.
    function automatic logic [9:0] sum_sat(input logic [3:0][8:0] p);
        logic [10:0] t;
        t = 11'(p[0]) + 11'(p[1]) + 11'(p[2]) + 11'(p[3]);
        sum_sat = t[10] ? 10'h3FF : t[9:0];
    endfunction : sum_sat

    // A start wipes all history so that a restarted conversion owes nothing to the old one.
    always_comb begin
        logic [8:0] slice;
        logic slice_end;
        slice = 9'h000;
        slice_end = 1'b0;
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.cnt = 13'h0000;
            s_d.acc = 9'h000;
            s_d.part = '0;
        end else if (run) begin
            slice = s_q.acc + 9'(mod_bit);
            slice_end = (s_q.cnt[7:0] == 8'hFF);
            s_d.acc = slice_end ? 9'h000 : slice;
            if (slice_end) begin
                s_d.part = {s_q.part[2:0], slice};
            end
            s_d.cnt = s_q.cnt + 13'h0001;
            // Continuous results every slice, single-shot after the full settling time.
            if (repeat_mode ? slice_end : (s_q.cnt == `ADC_SINGLE_CYCLES - 13'h0001)) begin
                s_d.done = 1'b1;
                s_d.result = sum_sat(s_d.part);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign result = s_q.result;

endmodule : conv_engine
